// ---- clock_gating_pkg.sv ----
package clock_gating_pkg;
   // ---------------------------------------------------------------
   // Configuration space offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OUTPUT_DISABLE_OFFSET = 8'hD8;
   localparam logic [7:0] SHED_SELECT_OFFSET    = 8'hD9;
   localparam logic [7:0] RUN_STATE_OFFSET      = 8'hDA;

   // ---------------------------------------------------------------
   // Field layout and reset values
   // ---------------------------------------------------------------
   localparam int         OUTPUT_COUNT          = 7;
   localparam int         REG_WIDTH             = 8;
   localparam int         STOPPED_BIT           = 0;
   localparam logic [7:0] OUTPUT_DISABLE_RESET  = 8'h00;
   localparam logic [7:0] SHED_SELECT_RESET     = 8'h00;
   localparam logic       RUN_STATE_RESET       = 1'h0;
   localparam logic [7:0] UNMAPPED_READ         = 8'h00;

   // ---------------------------------------------------------------
   // Slot power policy codes
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      POLICY_IGNORE     = 3'h0,
      POLICY_OVERRIDE   = 3'h1,
      POLICY_SHED       = 3'h2,
      POLICY_SHED_OVRD  = 3'h3,
      POLICY_UNSUPP     = 3'h4
   } policy_t;
endpackage

// ---- gate_if.sv ----
// Carries the gating controls from the register side to the stop logic
interface gate_if #(
   parameter int N = 7
);
   logic [N-1:0] off;
   logic [N-1:0] shed;
   logic         shed_on;
   logic         d3_stop;
   logic [N-1:0] stop;

   modport ctl  (output off, output shed, output shed_on, output d3_stop,
                 input stop);
   modport calc (input off, input shed, input shed_on, input d3_stop,
                 output stop);
endinterface

// ---- clock_stop_calc.sv ----
module clock_stop_calc #(
   parameter int N = 7
) (
   gate_if.calc g
);
   // ---------------------------------------------------------------
   // Stop decision per output
   // ---------------------------------------------------------------
   // Direct disable, shedding when active, or D3 stop
   assign g.stop = g.off
                 | (g.shed & {N{g.shed_on}})
                 | {N{g.d3_stop}};
endmodule

// ---- secondary_clock_gating.sv ----
// Summary of operation
// - Disable register bits 6..0 each stop one clock output; reset clears them.
// - Bit 7 of disable and shed select registers reads zero, ignores writes.
// - Shed select bits stop outputs while policy 010/011 and power short.
// - Shed select has no effect under other policies or sufficient power.
// - Run state bit 0 reads 1 when all clocks stopped, follows hardware, resets 0.
// - Run state bits 7..1 always read zero.
// - Policy 010 sheds clocks; 011 sheds and asserts power override output.
// - With D3 stop enable set, clocks stop while the bridge is in D3.
// - Link reset, global reset or power-on reset restore all defaults.
module secondary_clock_gating #(
   parameter int N = clock_gating_pkg::OUTPUT_COUNT
) (
   input  wire logic         clock,
   input  wire logic         srst,
   input  wire logic         fundamental_link_reset_n,
   input  wire logic         global_reset_input_n,
   input  wire logic [7:0]   cfg_addr,
   input  wire logic         cfg_wr,
   input  wire logic [7:0]   cfg_wdata,
   input  wire logic         cfg_rd,
   output logic      [7:0]   cfg_rdata,
   input  wire logic [2:0]   slot_power_policy,
   input  wire logic         slot_power_short,
   input  wire logic         d3_clock_stop_enable,
   input  wire logic         d3_state,
   output logic      [N-1:0] secondary_clock_output_on,
   output logic              power_override_out
);
   // ---------------------------------------------------------------
   // Elaboration check
   // ---------------------------------------------------------------
   if (N < 1 || N > clock_gating_pkg::REG_WIDTH - 1) begin : g_bad_n
      $error("N must be between 1 and 7");
   end

   // ---------------------------------------------------------------
   // Reset pin synchronisers
   // ---------------------------------------------------------------
   logic [1:0] fundamental_link_reset_sync_r;
   logic [1:0] global_reset_input_sync_r;
   logic       any_reset;

   // Two stages each; only the second stage is read
   always_ff @(posedge clock) begin
      if (srst) begin
         fundamental_link_reset_sync_r <= 2'h3;
         global_reset_input_sync_r  <= 2'h3;
      end else begin
         fundamental_link_reset_sync_r <= {fundamental_link_reset_sync_r[0], fundamental_link_reset_n};
         global_reset_input_sync_r  <= {global_reset_input_sync_r[0], global_reset_input_n};
      end
   end

   // Power-on, link and global reset all restore defaults
   assign any_reset = srst | ~fundamental_link_reset_sync_r[1] | ~global_reset_input_sync_r[1];

   // ---------------------------------------------------------------
   // Registers and decode
   // ---------------------------------------------------------------
   logic [N-1:0] off_r;
   logic [N-1:0] off_nxt;
   logic [N-1:0] shed_r;
   logic [N-1:0] shed_nxt;
   logic         stopped_r;
   logic [7:0]   cfg_rdata_nxt;
   logic         hit_off;
   logic         hit_shed;
   logic         hit_run;
   logic         shed_on;
   logic         d3_stop;
   logic         all_stopped;
   logic [N-1:0] stop;
   logic [7:0]   off_read;
   logic [7:0]   shed_read;
   logic [7:0]   run_read;

   assign hit_off  = cfg_addr == clock_gating_pkg::OUTPUT_DISABLE_OFFSET;
   assign hit_shed = cfg_addr == clock_gating_pkg::SHED_SELECT_OFFSET;
   assign hit_run  = cfg_addr == clock_gating_pkg::RUN_STATE_OFFSET;

   // Only low N bits are stored; bit 7 is dropped on write
   assign off_nxt  = (cfg_wr && hit_off)  ? cfg_wdata[N-1:0] : off_r;
   assign shed_nxt = (cfg_wr && hit_shed) ? cfg_wdata[N-1:0] : shed_r;

   // Read images padded with zero above the stored bits
   assign off_read  = {{(8-N){1'b0}}, off_r};
   assign shed_read = {{(8-N){1'b0}}, shed_r};
   assign run_read  = {7'h00, stopped_r};

   // Read multiplexer, unmapped offsets return zero
   assign cfg_rdata_nxt = !cfg_rd  ? cfg_rdata :
                          hit_off  ? off_read  :
                          hit_shed ? shed_read :
                          hit_run  ? run_read  :
                          clock_gating_pkg::UNMAPPED_READ;

   // Shedding only under the two shedding policies with power short
   assign shed_on = slot_power_short
                  && (slot_power_policy == clock_gating_pkg::POLICY_SHED
                  || slot_power_policy == clock_gating_pkg::POLICY_SHED_OVRD);
   assign d3_stop = d3_clock_stop_enable && d3_state;
   assign all_stopped = &stop;

   // ---------------------------------------------------------------
   // Stop calculation
   // ---------------------------------------------------------------
   gate_if #(.N(N)) g ();
   assign g.off     = off_r;
   assign g.shed    = shed_r;
   assign g.shed_on = shed_on;
   assign g.d3_stop = d3_stop;
   assign stop      = g.stop;

   clock_stop_calc #(.N(N)) i_clock_stop_calc (
      .g (g.calc)
   );

   // Configuration registers
   always_ff @(posedge clock) begin
      if (any_reset) begin
         off_r  <= clock_gating_pkg::OUTPUT_DISABLE_RESET[N-1:0];
         shed_r <= clock_gating_pkg::SHED_SELECT_RESET[N-1:0];
      end else begin
         off_r  <= off_nxt;
         shed_r <= shed_nxt;
      end
   end

   // Output gates, status and read data
   always_ff @(posedge clock) begin
      if (any_reset) begin
         secondary_clock_output_on <= {N{1'b1}};
         stopped_r                 <= clock_gating_pkg::RUN_STATE_RESET;
         power_override_out        <= 1'b0;
         cfg_rdata                 <= 8'h00;
      end else begin
         secondary_clock_output_on <= ~stop;
         stopped_r                 <= all_stopped;
         power_override_out        <= slot_power_short
            && slot_power_policy == clock_gating_pkg::POLICY_SHED_OVRD;
         cfg_rdata                 <= cfg_rdata_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (any_reset);

   off_write_a: assert property (
      cfg_wr && hit_off ##1 !any_reset |->
         ##1 (secondary_clock_output_on & $past(cfg_wdata[N-1:0], 2)) == '0)
      else $error("disabled output still running");

   off_store_a: assert property (
      cfg_wr && hit_off |=> off_r == $past(cfg_wdata[N-1:0]))
      else $error("disable write not stored");

   shed_store_a: assert property (
      cfg_wr && hit_shed |=> shed_r == $past(cfg_wdata[N-1:0]))
      else $error("shed select write not stored");

   resv_read_a: assert property (
      cfg_rd && (hit_off || hit_shed) |=> cfg_rdata[7] == 1'b0)
      else $error("reserved bit 7 read nonzero");

   shed_stop_a: assert property (
      shed_on && shed_r[0] |=> !secondary_clock_output_on[0])
      else $error("shed output not stopped");

   shed_ignored_a: assert property (
      !shed_on && !d3_stop && off_r == 0 |=> &secondary_clock_output_on)
      else $error("shed select acted while inactive");

   status_read_a: assert property (
      cfg_rd && hit_run |=> cfg_rdata[0] == $past(stopped_r))
      else $error("run state read wrong");

   status_set_a: assert property (
      &stop |=> stopped_r)
      else $error("run state not set with clocks stopped");

   status_clear_a: assert property (
      !(&stop) |=> !stopped_r)
      else $error("run state set with clocks running");

   status_resv_a: assert property (
      cfg_rd && hit_run |=> cfg_rdata[7:1] == 7'h00)
      else $error("run state reserved bits nonzero");

   either_stop_a: assert property (
      secondary_clock_output_on == ($past(any_reset) ? {N{1'b1}}
         : ~$past(off_r | (shed_r & {N{shed_on}}) | {N{d3_stop}})))
      else $error("output gate mismatch");

   ovrd_out_a: assert property (
      slot_power_policy == clock_gating_pkg::POLICY_SHED && slot_power_short
      |=> !power_override_out)
      else $error("override asserted for shed-only policy");

   ovrd_set_a: assert property (
      slot_power_short
      && slot_power_policy == clock_gating_pkg::POLICY_SHED_OVRD
      |=> power_override_out)
      else $error("override not asserted for shed-override policy");

   ovrd_idle_a: assert property (
      !slot_power_short |=> !power_override_out)
      else $error("override asserted with ample power");

   d3_stop_a: assert property (
      d3_clock_stop_enable && d3_state
      |=> secondary_clock_output_on == '0 && stopped_r)
      else $error("clocks not stopped in D3");

   d3_ignored_a: assert property (
      d3_state && !d3_clock_stop_enable && !shed_on && off_r == '0
      |=> &secondary_clock_output_on)
      else $error("clocks stopped in D3 without enable");

   reset_dflt_a: assert property (disable iff (1'b0)
      any_reset |=> off_r == 0 && shed_r == 0 && !stopped_r)
      else $error("defaults not restored by reset");

   reset_outs_a: assert property (disable iff (1'b0)
      any_reset |=> &secondary_clock_output_on && cfg_rdata == 8'h00
         && !power_override_out)
      else $error("outputs not at defaults during reset");
endmodule

// ---- clock_sink_model.sv ----
// Secondary bus devices: flag which outputs they see stopped
module clock_sink_model (
   input  wire logic       clock,
   input  wire logic [6:0] clock_seen,
   output logic      [6:0] stopped_r
);
   timeunit 1ns;
   timeprecision 1ps;
   // Registered view, as a device would notice one cycle late
   always_ff @(posedge clock) begin
      stopped_r <= ~clock_seen;
   end
endmodule

// ---- secondary_clock_gating_tb_top.sv ----
module secondary_clock_gating_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clock = 0, srst = 1, link_n = 1, glob_n = 1;
   logic       wr = 0, rd = 0, short = 0, d3en = 0, d3 = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic [2:0] policy = 3'h0;
   logic [6:0] on, stopped;
   logic       ovrd;
   int         miscompares = 0, comparisons = 0, cycles = 0;
   secondary_clock_gating i_secondary_clock_gating (.clock(clock),
      .srst(srst), .fundamental_link_reset_n(link_n),
      .global_reset_input_n(glob_n), .cfg_addr(addr), .cfg_wr(wr),
      .cfg_wdata(wdata), .cfg_rd(rd), .cfg_rdata(rdata),
      .slot_power_policy(policy), .slot_power_short(short),
      .d3_clock_stop_enable(d3en), .d3_state(d3),
      .secondary_clock_output_on(on), .power_override_out(ovrd));
   clock_sink_model i_clock_sink_model (.clock(clock), .clock_seen(on),
      .stopped_r(stopped));
   always #2 clock = ~clock;
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic give_verdict();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic check(input string w, input logic [7:0] s, e);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, d);
      @(negedge clock);
      addr = a; wdata = d; wr = 1;
      @(negedge clock);
      wr = 0;
      repeat (4) @(negedge clock);
   endtask
   task automatic rd_chk(input logic [7:0] a, e);
      @(negedge clock);
      addr = a; rd = 1;
      @(negedge clock);
      rd = 0;
      @(negedge clock);
      check($sformatf("reg %h", a), rdata, e);
   endtask
   task automatic settle();
      repeat (4) @(negedge clock);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_defaults();
      rd_chk(8'hD8, 8'h00);
      rd_chk(8'hD9, 8'h00);
      rd_chk(8'hDA, 8'h00);
      rd_chk(8'h40, 8'h00);
      check("on", {1'b0, on}, 8'h7F);
      $display("defaults done");
   endtask
   task automatic t_disable();
      wr_reg(8'hD8, 8'hFF);
      rd_chk(8'hD8, 8'h7F);
      check("on", {1'b0, on}, 8'h00);
      check("sink", {1'b0, stopped}, 8'h7F);
      rd_chk(8'hDA, 8'h01);
      wr_reg(8'hDA, 8'hFE);
      rd_chk(8'hDA, 8'h01);
      wr_reg(8'hD8, 8'h05);
      check("on", {1'b0, on}, 8'h7A);
      rd_chk(8'hDA, 8'h00);
      wr_reg(8'hD8, 8'h00);
      $display("disable done");
   endtask
   task automatic t_shed();
      wr_reg(8'hD9, 8'h83);
      rd_chk(8'hD9, 8'h03);
      short = 1;
      for (int p = 0; p < 8; p++) begin
         policy = p[2:0];
         settle();
         check("shed", {1'b0, on}, (p == 2 || p == 3) ? 8'h7C : 8'h7F);
         check("ovrd", {7'h00, ovrd}, {7'h00, p == 3});
      end
      policy = 3'h2;
      wr_reg(8'hD8, 8'h40);
      check("both", {1'b0, on}, 8'h3C);
      short = 0;
      settle();
      check("ample", {1'b0, on}, 8'h3F);
      wr_reg(8'hD8, 8'h00);
      $display("shed done");
   endtask
   task automatic t_d3();
      d3en = 1; d3 = 1;
      settle();
      check("d3", {1'b0, on}, 8'h00);
      rd_chk(8'hDA, 8'h01);
      d3en = 0;
      settle();
      check("d3 off", {1'b0, on}, 8'h7F);
      d3 = 0;
      $display("d3 done");
   endtask
   task automatic t_pins();
      for (int k = 0; k < 2; k++) begin
         wr_reg(8'hD8, 8'h0F);
         wr_reg(8'hD9, 8'h0F);
         if (k == 0) link_n = 0;
         else glob_n = 0;
         settle();
         link_n = 1; glob_n = 1;
         settle();
         rd_chk(8'hD8, 8'h00);
         rd_chk(8'hD9, 8'h00);
         check("pin on", {1'b0, on}, 8'h7F);
      end
      $display("pins done");
   endtask
   // Cut a hang short
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         give_verdict();
      end
   end
   initial begin
      repeat (12) @(negedge clock);
      srst = 0;
      t_defaults();
      t_disable();
      t_shed();
      t_d3();
      t_pins();
      give_verdict();
   end
endmodule
